// File: tb/kms_checker.sv
// port-level assertions for the key-matrix scanner
`timescale 1ns/1ps
module kms_checker #(parameter OSC_DIV = 4, parameter SLOT_T = 384, parameter SCAN_T = 2304, parameter REQ_T = 4800) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// matrix, request line, oscillator
	input wire [5:0] scan_drive_o,
	input wire [4:0] return_sense_i,
	input wire read_request_out_o,
	input wire read_request_out_oe_o,
	input wire rc_osc_run_o
);
	reg [5:0] cfg_reg;
	reg [5:0] old_reg;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// shadow of the level setting; the older copy tolerates a drive update one clock late
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= 6'h00;
			old_reg <= 6'h00;
		end else begin
			old_reg <= cfg_reg;
			if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
				cfg_reg <= wb_dat_i[5:0];
		end
	end
	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_od_low; read_request_out_o == 1'b0; endproperty
	a_od_low: assert property (p_od_low) else $error("line driven high");
	property p_rst_idle; $fell(rst_i) |-> scan_drive_o == 6'h00 && !read_request_out_oe_o; endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("active after reset");
	property p_wake; return_sense_i != 5'h00 |-> ##[0:6] rc_osc_run_o; endproperty
	a_wake: assert property (p_wake) else $error("oscillator stays off");
	property p_keys_top; wb_ack_o && !wb_we_i && wb_adr_i == 8'h08 |-> wb_dat_o[31:30] == 2'b00; endproperty
	a_keys_top: assert property (p_keys_top) else $error("key word too wide");
	property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c |-> wb_dat_o == 32'h0000_0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_low_lines; (scan_drive_o & ~cfg_reg & ~old_reg) == 6'h00; endproperty
	a_low_lines: assert property (p_low_lines) else $error("low line pulsed");
	c_req: cover property ($rose(read_request_out_oe_o));
	c_write: cover property (wb_ack_o && wb_we_i);
	c_sleep: cover property ($fell(rc_osc_run_o));
endmodule

bind kms_scanner kms_checker #(.OSC_DIV(OSC_DIV), .SLOT_T(SLOT_T), .SCAN_T(SCAN_T), .REQ_T(REQ_T)) kms_checker_i (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.scan_drive_o(scan_drive_o), .return_sense_i(return_sense_i), .read_request_out_o(read_request_out_o),
	.read_request_out_oe_o(read_request_out_oe_o), .rc_osc_run_o(rc_osc_run_o));

// File: tb/kms_ctl_model.sv
// serial controller model: opens key reads and samples the shared line
`timescale 1ns/1ps
module kms_ctl_model (
	// serial link pins
	output reg shift_pulse_pin_o,
	output reg chip_select_pin_o,
	output reg serial_in_pin_o,
	// wire level of the open-drain line
	input wire line_i
);
	// shift clock stands still between frames
	initial begin
		shift_pulse_pin_o = 1'b0;
		chip_select_pin_o = 1'b0;
		serial_in_pin_o = 1'b0;
	end
	// address goes out lsb first, then 31 bits are sampled on rising edges
	task read_keys(input [7:0] adr, input idle_high, output [30:0] bits);
		integer n;
		begin
			for (n = 0; n < 8; n = n + 1) begin
				shift_pulse_pin_o <= 1'b0;
				serial_in_pin_o <= adr[n];
				#160 shift_pulse_pin_o <= 1'b1;
				#160;
			end
			shift_pulse_pin_o <= idle_high;
			#160 chip_select_pin_o <= 1'b1;
			#160;
			for (n = 0; n < 31; n = n + 1) begin
				shift_pulse_pin_o <= 1'b0;
				#160 shift_pulse_pin_o <= 1'b1;
				bits[n] = line_i;
				#160;
			end
			shift_pulse_pin_o <= idle_high;
			#160 chip_select_pin_o <= 1'b0;
			#160;
		end
	endtask
endmodule

// File: tb/test_key_matrix_scanner_readout.sv
// self-checking bench for the key-matrix scanner
`timescale 1ns/1ps
module test_key_matrix_scanner_readout;
	localparam OSC = 2;
	localparam REQ = 100;
	reg clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	reg [7:0] adr = 8'h00;
	reg [3:0] sel = 4'h0;
	reg [31:0] wdat = 32'h0000_0000, rd;
	reg [4:0] ret = 5'h00;
	reg [29:0] keys = 30'h0000_0000, k, exp;
	reg [5:0] cfg;
	reg [30:0] bits;
	wire [31:0] rdat;
	wire [5:0] drive;
	wire ack, od, oe, osc, sck, cs, sdi;
	wire line = oe ? od : 1'b1;
	integer fail_count = 0, comparisons = 0, ncyc = 0, t, i;
	kms_scanner #(.OSC_DIV(OSC), .SLOT_T(8), .SCAN_T(48), .REQ_T(REQ)) kms_scanner_i (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .scan_drive_o(drive), .return_sense_i(ret),
		.shift_pulse_pin_i(sck), .chip_select_pin_i(cs), .serial_in_pin_i(sdi), .read_request_out_i(line),
		.read_request_out_o(od), .read_request_out_oe_o(oe), .rc_osc_run_o(osc));
	kms_ctl_model kms_ctl_model_i (.shift_pulse_pin_o(sck), .chip_select_pin_o(cs), .serial_in_pin_o(sdi),
		.line_i(line));
	always #20 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		ncyc = ncyc + 1;
		if (ncyc == 40000) begin
			fail_count = fail_count + 1;
			test_done;
		end
	end
	// pressed keys connect a high drive line to its return; one clock of wiring lag
	function [4:0] sense(input [5:0] d, input [29:0] kk);
		integer a, b;
		begin
			sense = 5'h00;
			for (a = 0; a < 6; a = a + 1)
				for (b = 0; b < 5; b = b + 1)
					if (d[a] && kk[a*5+b])
						sense[b] = 1'b1;
		end
	endfunction
	// keys behind lines set low never show
	function [29:0] want_keys(input [5:0] c, input [29:0] kk);
		integer a;
		begin
			for (a = 0; a < 6; a = a + 1)
				want_keys[a*5 +: 5] = c[a] ? kk[a*5 +: 5] : 5'h00;
		end
	endfunction
	// set bits of a key word; a controller drops words with three or more
	function integer ones(input [29:0] w);
		integer a;
		begin
			ones = 0;
			for (a = 0; a < 30; a = a + 1)
				ones = ones + w[a];
		end
	endfunction
	always @(posedge clk) ret <= sense(drive, keys);
	task chk(input [31:0] seen, input [31:0] want);
		begin
			comparisons = comparisons + 1;
			if (seen !== want) begin
				fail_count = fail_count + 1;
				$display("MISMATCH %0t seen %h want %h", $time, seen, want);
			end
		end
	endtask
	// one classic cycle, held until ack is sampled
	task wb(input w, input [7:0] a, input [3:0] s, input [31:0] d);
		begin
			@(posedge clk);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			sel <= s;
			wdat <= d;
			@(posedge clk);
			while (ack !== 1'b1)
				@(posedge clk);
			rd = rdat;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask
	task wait_req(input integer lim);
		begin
			i = 0;
			while (line !== 1'b0 && i < lim) begin
				@(posedge clk);
				i = i + 1;
			end
		end
	endtask
	task test_done;
		begin
			if (fail_count == 0 && comparisons > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		i = $urandom(32'h0000_103a);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wb(0, 8'h04, 4'hf, 32'h0000_0000);
		chk(rd[3], 0);
		wb(0, 8'h0c, 4'hf, 32'h0000_0000);
		chk(rd, 0);
		for (t = 0; t < 4; t = t + 1) begin
			cfg = (t == 0) ? 6'h3c : ($urandom | 6'h20);
			wb(1, 8'h00, 4'h3, {23'h0, t == 3, 2'b00, cfg});
			repeat (4) @(posedge clk);
			chk(drive, cfg);
			chk(osc, t != 3);
			// a press shorter than the debounce window is never reported
			keys <= 30'h0000_0001 << (25 + $urandom % 5);
			repeat (40) @(posedge clk);
			keys <= 30'h0000_0000;
			repeat (500) @(posedge clk);
			chk(line, 1);
			k = (30'h0000_0001 << ($urandom % 30)) | (30'h0000_0001 << (25 + $urandom % 5));
			exp = want_keys(cfg, k);
			keys <= k;
			wait_req(2000);
			chk(i >= REQ * OSC && i <= REQ * OSC + 20, 1);
			if (line === 1'b0) begin
				kms_ctl_model_i.read_keys(8'h42, t[0], bits);
				chk(bits, 31'h7fff_ffff);
				wait_req(100);
				chk(line, 0);
				kms_ctl_model_i.read_keys(8'h43, t[0], bits);
				chk(bits, {t == 3, exp});
				chk(ones(bits[29:0]) < 3, 1);
			end
			repeat (8) @(posedge clk);
			chk(line, 1);
			wb(0, 8'h08, 4'hf, 32'h0000_0000);
			chk(rd, {2'b00, exp});
			wait_req(400);
			chk(line, 0);
			if (t == 3) begin
				wb(0, 8'h00, 4'hf, 32'h0000_0000);
				chk(rd[8], 1);
				wb(1, 8'h00, 4'h2, 32'h0000_0000);
				wb(0, 8'h00, 4'hf, 32'h0000_0000);
				chk(rd[8], 0);
				chk(osc, 1);
			end
			keys <= 30'h0000_0000;
			kms_ctl_model_i.read_keys(8'h43, 1'b0, bits);
			repeat (400) @(posedge clk);
			chk(line, 1);
			chk(drive, cfg);
		end
		test_done;
	end
endmodule

// File: verilog/kms_defines.vh
// constants of the key-matrix scanner with serial key readout
`ifndef KMS_DEFINES_VH
`define KMS_DEFINES_VH

// ----------------------------------------
// register map (byte addresses, 32-bit words)
// ----------------------------------------
`define KMS_ADDR_CTRL 8'h00
`define KMS_ADDR_STATUS 8'h04
`define KMS_ADDR_KEYS 8'h08

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define KMS_CTRL_CFG_LSB 0
`define KMS_CTRL_SLEEP_BIT 8
`define KMS_CFG_RESET 6'h00
`define KMS_STAT_REQ_BIT 0
`define KMS_STAT_SCAN_BIT 1
`define KMS_STAT_SLEEP_BIT 2
`define KMS_STAT_EN_BIT 3
`define KMS_STAT_PIN_BIT 4

// ----------------------------------------
// serial link and timing (oscillator periods)
// ----------------------------------------
`define KMS_READ_ADDR 8'h43
`define KMS_READ_BITS 31
`define KMS_SLOT_T 384
`define KMS_SCAN_T 2304
`define KMS_REQ_T 4800
`define KMS_OSC_DIV 4

`endif

// File: verilog/kms_scanner.v
// key-matrix scanner with debounce, open-drain request and serial key readout
`timescale 1ns/1ps
`include "kms_defines.vh"
module kms_scanner #(
	parameter OSC_DIV = `KMS_OSC_DIV,
	parameter SLOT_T = `KMS_SLOT_T,
	parameter SCAN_T = `KMS_SCAN_T,
	parameter REQ_T = `KMS_REQ_T
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// key matrix
	output reg [5:0] scan_drive_o,
	input wire [4:0] return_sense_i,
	// serial link
	input wire shift_pulse_pin_i,
	input wire chip_select_pin_i,
	input wire serial_in_pin_i,
	// open-drain data out / read request line
	input wire read_request_out_i,
	output wire read_request_out_o,
	output wire read_request_out_oe_o,
	// oscillator activity
	output wire rc_osc_run_o
);

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	wire [8:0] pins_sync;
	kms_sync2 #(
		.WIDTH(9)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({read_request_out_i, serial_in_pin_i, chip_select_pin_i, shift_pulse_pin_i, return_sense_i}),
		.sync_o(pins_sync)
	);
	wire [4:0] ret_s = pins_sync[4:0];
	wire cl_s = pins_sync[5];
	wire ce_s = pins_sync[6];
	wire di_s = pins_sync[7];
	wire line_s = pins_sync[8];

	// ----------------------------------------
	// state and storage
	// ----------------------------------------
	localparam ST_IDLE = 5'b00001;
	localparam ST_SCAN1 = 5'b00010;
	localparam ST_SCAN2 = 5'b00100;
	localparam ST_WAIT = 5'b01000;
	localparam ST_REQ = 5'b10000;

	reg [4:0] state_reg;
	reg [5:0] cfg_reg;
	reg sleep_reg;
	reg scan_en_reg;
	reg [29:0] key_reg;
	reg sleep_flag_reg;
	reg [29:0] first_reg;
	reg [29:0] cur_reg;
	reg [12:0] tcnt_reg;
	reg [8:0] pos_reg;
	reg [2:0] slot_reg;
	reg [7:0] div_reg;
	reg tick_reg;
	reg cl_d_reg;
	reg ce_d_reg;
	reg [7:0] addr_sr_reg;
	reg xfer_reg;
	reg rise_seen_reg;
	reg [4:0] bit_idx_reg;
	reg [5:0] rise_cnt_reg;

	// a key press is visible in standby whenever a high line shorts to a return
	wire key_now = (|ret_s) & scan_en_reg & (|cfg_reg);
	wire scanning = state_reg[1] | state_reg[2] | state_reg[3];
	wire read_done = ce_d_reg & ~ce_s & xfer_reg & (rise_cnt_reg >= `KMS_READ_BITS);

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr_ctrl = wb_req & wb_we_i & (wb_adr_i == `KMS_ADDR_CTRL);

	// one wait state; unmapped reads answer zero, unmapped writes are dropped
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req & ~wb_we_i) begin
				case (wb_adr_i)
					`KMS_ADDR_CTRL: wb_dat_o <= {23'h00_0000, sleep_reg, 2'b00, cfg_reg};
					`KMS_ADDR_STATUS: wb_dat_o <= {27'h000_0000, line_s, scan_en_reg, sleep_flag_reg,
						scanning, state_reg[4]};
					`KMS_ADDR_KEYS: wb_dat_o <= {2'b00, key_reg};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// control register; a write lands whatever the request line shows
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= `KMS_CFG_RESET;
			sleep_reg <= 1'b0;
			scan_en_reg <= 1'b0;
		end else if (wr_ctrl) begin
			if (wb_sel_i[0]) begin
				cfg_reg <= wb_dat_i[5:0];
				scan_en_reg <= 1'b1;
			end
			// only this write changes the mode; reading keys in sleep leaves it set
			if (wb_sel_i[1])
				sleep_reg <= wb_dat_i[`KMS_CTRL_SLEEP_BIT];
		end
	end

	// ----------------------------------------
	// oscillator period enable
	// ----------------------------------------
	// in sleep the oscillator stops until a key press or pending work needs it
	// a held key keeps it running while a request waits, so debounce timing never stalls
	assign rc_osc_run_o = ~sleep_reg | scanning | key_now;

	// the divider restarts from zero each time the oscillator starts, so the first period is whole
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else if (rc_osc_run_o) begin
			tick_reg <= (div_reg == OSC_DIV - 1);
			div_reg <= (div_reg == OSC_DIV - 1) ? 8'h00 : div_reg + 8'h01;
		end else begin
			div_reg <= 8'h00;
			tick_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// scan sequencer
	// ----------------------------------------
	integer s;
	integer i;
	reg [29:0] cur_next;

	// a scan ends on the period count, which ties the slot width to the full scan length
	wire scan_last = (tcnt_reg == SCAN_T - 1) || (tcnt_reg == 2 * SCAN_T - 1);

	// sample the returns at the last period of each drive slot, high lines only
	always @* begin
		cur_next = cur_reg;
		for (s = 0; s < 6; s = s + 1) begin
			for (i = 0; i < 5; i = i + 1) begin
				if (slot_reg == s)
					cur_next[s * 5 + i] = cfg_reg[s] & ret_s[i];
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			key_reg <= 30'h0000_0000;
			sleep_flag_reg <= 1'b0;
			first_reg <= 30'h0000_0000;
			cur_reg <= 30'h0000_0000;
			tcnt_reg <= 13'h0000;
			pos_reg <= 9'h000;
			slot_reg <= 3'h0;
		end else begin
			case (state_reg)
				// counters start from zero so every scan has the same length
				ST_IDLE: begin
					tcnt_reg <= 13'h0000;
					pos_reg <= 9'h000;
					slot_reg <= 3'h0;
					if (key_now)
						state_reg <= ST_SCAN1;
				end
				ST_SCAN1, ST_SCAN2: begin
					if (tick_reg) begin
						tcnt_reg <= tcnt_reg + 13'h0001;
						if (pos_reg == SLOT_T - 1) begin
							cur_reg <= cur_next;
							pos_reg <= 9'h000;
							if (scan_last) begin
								slot_reg <= 3'h0;
								if (state_reg == ST_SCAN1) begin
									first_reg <= cur_next;
									state_reg <= ST_SCAN2;
								end else
									state_reg <= ST_WAIT;
							end else
								slot_reg <= slot_reg + 3'h1;
						end else
							pos_reg <= pos_reg + 9'h001;
					end
				end
				// the request interval runs from the start of the first scan
				ST_WAIT: begin
					if (tick_reg) begin
						tcnt_reg <= tcnt_reg + 13'h0001;
						if (tcnt_reg == REQ_T - 1) begin
							tcnt_reg <= 13'h0000;
							// an empty or changed word never raises the request
							if ((first_reg == cur_reg) && (|cur_reg)) begin
								key_reg <= cur_reg;
								sleep_flag_reg <= sleep_reg;
								state_reg <= ST_REQ;
							end else if (key_now)
								state_reg <= ST_SCAN1;
							else
								state_reg <= ST_IDLE;
						end
					end
				end
				ST_REQ: begin
					// a finished read releases the line and looks again
					if (read_done)
						state_reg <= ST_SCAN1;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// drive lines: standby levels, or a single moving pulse on high lines
	// low lines never pulse, so keys behind them can never read as pressed
	always @(posedge clk_i) begin
		if (rst_i)
			scan_drive_o <= 6'h00;
		else if (state_reg[1] | state_reg[2])
			scan_drive_o <= cfg_reg & (6'h01 << slot_reg);
		else
			scan_drive_o <= cfg_reg;
	end

	// ----------------------------------------
	// serial readout
	// ----------------------------------------
	// address arrives lsb first on rising shift edges with chip select low
	always @(posedge clk_i) begin
		if (rst_i) begin
			cl_d_reg <= 1'b0;
			ce_d_reg <= 1'b0;
			addr_sr_reg <= 8'h00;
			xfer_reg <= 1'b0;
			rise_seen_reg <= 1'b0;
			bit_idx_reg <= 5'h00;
			rise_cnt_reg <= 6'h00;
		end else begin
			cl_d_reg <= cl_s;
			ce_d_reg <= ce_s;
			if (~ce_s & cl_s & ~cl_d_reg)
				addr_sr_reg <= {di_s, addr_sr_reg[7:1]};
			// chip select rising closes the address phase and opens the data phase
			if (ce_s & ~ce_d_reg) begin
				xfer_reg <= (addr_sr_reg == `KMS_READ_ADDR);
				rise_seen_reg <= 1'b0;
				bit_idx_reg <= 5'h00;
				rise_cnt_reg <= 6'h00;
			end else if (~ce_s) begin
				xfer_reg <= 1'b0;
			end else if (xfer_reg) begin
				// advance on a falling edge only after a rising one, so either idle level works
				if (cl_s & ~cl_d_reg) begin
					rise_seen_reg <= 1'b1;
					if (rise_cnt_reg != 6'h3f)
						rise_cnt_reg <= rise_cnt_reg + 6'h01;
				end
				if (~cl_s & cl_d_reg & rise_seen_reg & (bit_idx_reg != 5'h1f))
					bit_idx_reg <= bit_idx_reg + 5'h01;
			end
		end
	end

	// bits past the sleep flag read as released
	wire out_bit = (bit_idx_reg < 5'h1e) ? key_reg[bit_idx_reg] :
		((bit_idx_reg == 5'h1e) ? sleep_flag_reg : 1'b1);

	// request pull: a verified key word waits to be read
	wire req_pull = state_reg[4];
	// data pull: a zero bit of an open key read; any other address leaves the line released
	wire data_pull = xfer_reg & ~out_bit;

	// open drain: only ever pulls low; chip select high hides the pending request
	assign read_request_out_o = 1'b0;
	assign read_request_out_oe_o = ce_s ? data_pull : req_pull;

endmodule

// File: verilog/kms_sync2.v
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module kms_sync2 #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// asynchronous in, synchronised out
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// first stage feeds only the second stage
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;

endmodule
